// ==== core/fuc_consts.vh ====
// Constants for the FIFO serial transceiver: register offsets, fields, reset values.
// Assumes inclusion by the top design file and the bench; definitions only.
`ifndef FUC_CONSTS_VH
`define FUC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FUC_DATA_PORT_OFF 12'h000
`define FUC_RX_STATUS_OFF 12'h004
`define FUC_FLAG_OFF 12'h018
`define FUC_INT_DIV_OFF 12'h024
`define FUC_FRAC_DIV_OFF 12'h028
`define FUC_LINE_CTRL_OFF 12'h02c
`define FUC_CONTROL_OFF 12'h030
`define FUC_LEVEL_SEL_OFF 12'h034
`define FUC_IRQ_MASK_OFF 12'h038
`define FUC_RAW_IRQ_OFF 12'h03c
`define FUC_MASKED_IRQ_OFF 12'h040
`define FUC_IRQ_CLEAR_OFF 12'h044

// ----------------------------------------
// Line control fields
// ----------------------------------------
`define FUC_LC_BREAK 0
`define FUC_LC_PAR_EN 1
`define FUC_LC_EVEN 2
`define FUC_LC_TWO_STOP 3
`define FUC_LC_FIFO_EN 4
`define FUC_LC_WLEN_LO 5
`define FUC_LC_STICK 7

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define FUC_CT_GLOBAL_EN 0
`define FUC_CT_LOOPBACK 7
`define FUC_CT_TX_EN 8
`define FUC_CT_RX_EN 9
`define FUC_CONTROL_RESET 10'h300
`define FUC_LEVEL_RESET 6'h12

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define FUC_IRQ_RX 4
`define FUC_IRQ_TX 5
`define FUC_IRQ_RTO 6
`define FUC_IRQ_FE 7
`define FUC_IRQ_PE 8
`define FUC_IRQ_BE 9
`define FUC_IRQ_OE 10

// ----------------------------------------
// Timing
// ----------------------------------------
`define FUC_RX_TIMEOUT_BITS 32

`endif

// ==== core/fuc_fifo.v ====
// Synchronous FIFO in flip-flops with a runtime depth limit of one entry.
// Assumes one clock; push is ignored when full, pop when empty.
`timescale 1ns/10ps
`default_nettype none

module fuc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH_LOG2 = 4
) (
    input wire clock_i, // System clock
    input wire rst_i, // Async reset, active high
    input wire deep_i, // High: full depth, low: one entry
    input wire push_i, // Write strobe
    input wire [WIDTH-1:0] data_i, // Write data
    input wire pop_i, // Read strobe
    output wire [WIDTH-1:0] data_o, // Head entry
    output wire empty_o, // No entries
    output wire full_o, // No room
    output wire [DEPTH_LOG2:0] count_o // Entries held
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [DEPTH_LOG2-1:0] wr_ptr;
    reg [DEPTH_LOG2-1:0] rd_ptr;
    reg [DEPTH_LOG2:0] count;
    wire do_push;
    wire do_pop;

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    assign empty_o = (count == {(DEPTH_LOG2+1){1'b0}});
    assign full_o = deep_i ? (count == DEPTH[DEPTH_LOG2:0]) : !empty_o;
    assign count_o = count;
    assign data_o = store[rd_ptr];
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;

    // Pointers and fill count
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= {DEPTH_LOG2{1'b0}};
            rd_ptr <= {DEPTH_LOG2{1'b0}};
            count <= {(DEPTH_LOG2+1){1'b0}};
        end else begin
            if (do_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end

    // Storage has no reset; data_o shows the entry at rd_ptr even when empty, written or not
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
            always @(posedge clock_i) begin
                if (do_push && wr_ptr == g)
                    store[g] <= data_i;
            end
        end
    endgenerate
endmodule // fuc_fifo

`default_nettype wire

// ==== core/fuc_tick.v ====
// Oversampling tick generator with a fractional divisor in sixty-fourths.
// Assumes a divisor integer part of at least one.
`timescale 1ns/10ps
`default_nettype none

module fuc_tick (
    input wire clock_i, // System clock
    input wire rst_i, // Async reset, active high
    input wire [15:0] div_int_i, // Integer divisor
    input wire [5:0] div_frac_i, // Fraction in 64ths
    output reg tick_o // One-cycle pulse at 16x baud
);
    reg [15:0] count;
    reg [5:0] acc;
    wire [6:0] acc_sum;
    wire [16:0] period;

    // Carry from the fraction stretches a period by one clock
    assign acc_sum = {1'b0, acc} + {1'b0, div_frac_i};
    assign period = {1'b0, div_int_i} + {16'h0000, acc_sum[6]};

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    // fractional accumulation
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 16'h0001;
            acc <= 6'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (div_int_i == 16'h0000) begin
                count <= 16'h0001;
            end else if ({1'b0, count} >= period) begin
                count <= 16'h0001;
                acc <= acc_sum[5:0];
                tick_o <= 1'b1;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule // fuc_tick

`default_nettype wire

// ==== core/fuc_core.v ====
// Contract
// - Separate transmit, receive enables; reset enabled
// - Frame: start, data LSB first, parity, stop
// - 5-8 bits, parity modes, 1-2 stops, break
// - Divisor 16-bit integer plus 6-bit fraction
// - 16x tick; divide by sixteen for bits
// - Shadow divisor loaded on line control write
// - 16-entry transmit and receive FIFOs
// - FIFO write starts frames, back to back
// - Busy until FIFO empty and stop sent
// - False start rejected at eighth tick
// - Sample data every sixteen ticks, check parity
// - Framing error; push data with flags
// - Data read pops 12 bits; write pushes
// - FIFOs one deep until enable bit set
// - Empty, full flags and overrun status
// - Level thresholds 1/8..7/8, reset 1/2
// - Seven sources ORed into one request
// - Masked equals raw AND mask
// - Write one clears interrupt source
// - Loopback routes transmit to receiver
//
// Top of the FIFO serial transceiver: AHB-Lite slave, transmitter, receiver.
// Assumes a single AHB-Lite master, word transfers only, one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "fuc_consts.vh"

module fuc_core (
    input wire clock_i, // System clock, 100 MHz
    input wire rst_i, // Async reset, active high
    input wire hsel_i, // Slave select
    input wire [11:0] haddr_i, // Byte address within block
    input wire [1:0] htrans_i, // Transfer type
    input wire hwrite_i, // Write when high
    input wire [2:0] hsize_i, // Transfer size, word only
    input wire hready_i, // Bus ready
    input wire [31:0] hwdata_i, // Write data
    output reg [31:0] hrdata_o, // Read data
    output wire hreadyout_o, // Always ready
    output wire hresp_o, // Always OKAY
    input wire serial_in_i, // Receive pin
    output reg serial_out_o, // Transmit pin
    output wire irq_o // Combined interrupt request
);
    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    reg ph_wr;
    reg ph_rd;
    reg [11:0] ph_addr;
    wire start = hsel_i && htrans_i[1] && hready_i;

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Registered address phase; zero wait state data phase
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 12'h000;
        end else begin
            ph_wr <= start && hwrite_i;
            ph_rd <= start && !hwrite_i;
            ph_addr <= {haddr_i[11:2], 2'b00};
        end
    end

    wire wr_at = ph_wr;
    wire wr_data = wr_at && ph_addr == `FUC_DATA_PORT_OFF;
    wire wr_lc = wr_at && ph_addr == `FUC_LINE_CTRL_OFF;
    wire wr_icr = wr_at && ph_addr == `FUC_IRQ_CLEAR_OFF;
    wire wr_ecr = wr_at && ph_addr == `FUC_RX_STATUS_OFF;
    // Pop is decided in the address phase so hrdata can be registered
    wire rd_data_now = start && !hwrite_i && {haddr_i[11:2], 2'b00} == `FUC_DATA_PORT_OFF;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    reg [15:0] div_int;
    reg [5:0] div_frac;
    reg [7:0] line_ctrl;
    reg [9:0] control;
    reg [5:0] level_sel;
    reg [10:0] irq_mask;
    reg [29:0] shadow;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_int <= 16'h0000;
            div_frac <= 6'h00;
            line_ctrl <= 8'h00;
            control <= `FUC_CONTROL_RESET;
            level_sel <= `FUC_LEVEL_RESET;
            irq_mask <= 11'h000;
            shadow <= 30'h00000000;
        end else if (wr_at) begin
            case (ph_addr)
                `FUC_INT_DIV_OFF: div_int <= hwdata_i[15:0];
                `FUC_FRAC_DIV_OFF: div_frac <= hwdata_i[5:0];
                `FUC_LINE_CTRL_OFF: begin
                    line_ctrl <= hwdata_i[7:0];
                    shadow <= {div_int, div_frac, hwdata_i[7:0]};
                end
                `FUC_CONTROL_OFF: control <= hwdata_i[9:0];
                `FUC_LEVEL_SEL_OFF: level_sel <= hwdata_i[5:0];
                `FUC_IRQ_MASK_OFF: irq_mask <= hwdata_i[10:0];
                default: ;
            endcase
        end
    end

    // Live line settings and divisor come from the shadow word; enables from control
    wire [7:0] lc = shadow[7:0];
    wire [1:0] wlen = lc[`FUC_LC_WLEN_LO+1:`FUC_LC_WLEN_LO];
    wire [3:0] nbits = {2'b00, wlen} + 4'd5;
    wire uart_en = control[`FUC_CT_GLOBAL_EN];
    wire tx_en = uart_en && control[`FUC_CT_TX_EN];
    wire rx_en = uart_en && control[`FUC_CT_RX_EN];
    wire deep = lc[`FUC_LC_FIFO_EN];

    wire tick;
    fuc_tick u_tick (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .div_int_i(shadow[29:14]),
        .div_frac_i(shadow[13:8]),
        .tick_o(tick)
    );

    // ----------------------------------------
    // FIFOs
    // ----------------------------------------
    wire [7:0] txf_data;
    wire txf_empty;
    wire txf_full;
    wire [4:0] txf_count;
    reg tx_pop;
    wire [11:0] rxf_data;
    wire rxf_empty;
    wire rxf_full;
    wire [4:0] rxf_count;
    reg rx_push;
    reg [11:0] rx_word;

    fuc_fifo #(.WIDTH(8), .DEPTH_LOG2(4)) u_txf (
        .clock_i(clock_i), .rst_i(rst_i), .deep_i(deep),
        .push_i(wr_data), .data_i(hwdata_i[7:0]), .pop_i(tx_pop),
        .data_o(txf_data), .empty_o(txf_empty), .full_o(txf_full),
        .count_o(txf_count)
    );

    fuc_fifo #(.WIDTH(12), .DEPTH_LOG2(4)) u_rxf (
        .clock_i(clock_i), .rst_i(rst_i), .deep_i(deep),
        .push_i(rx_push), .data_i(rx_word), .pop_i(rd_data_now),
        .data_o(rxf_data), .empty_o(rxf_empty), .full_o(rxf_full),
        .count_o(rxf_count)
    );

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    reg tx_busy_shift;
    reg [3:0] tx_tick_cnt;
    reg [3:0] tx_bit;
    reg [11:0] tx_frame;
    reg [3:0] tx_len;

    // Parity over configured bits; stick forces a constant
    function par_bit;
        input [7:0] d;
        input [3:0] n;
        input [7:0] l;
        reg p;
        begin
            p = ^(d & ~(8'hff << n));
            if (l[`FUC_LC_STICK])
                par_bit = !l[`FUC_LC_EVEN];
            else
                par_bit = l[`FUC_LC_EVEN] ? p : !p;
        end
    endfunction

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_busy_shift <= 1'b0;
            tx_tick_cnt <= 4'h0;
            tx_bit <= 4'h0;
            tx_frame <= 12'hfff;
            tx_len <= 4'h0;
            tx_pop <= 1'b0;
        end else begin
            tx_pop <= 1'b0;
            if (!tx_busy_shift) begin
                if (tx_en && !txf_empty && !tx_pop) begin
                    tx_busy_shift <= 1'b1;
                    tx_pop <= 1'b1;
                    tx_tick_cnt <= 4'h0;
                    tx_bit <= 4'h0;
                    tx_frame <= ({4'hf, txf_data} & ~(12'hfff << nbits)
                        | (12'hfff << (nbits + {3'b000, lc[`FUC_LC_PAR_EN]}))
                        | ({11'h000, par_bit(txf_data, nbits, lc)} << nbits)) << 1;
                    tx_len <= 4'd2 + nbits + {3'b000, lc[`FUC_LC_PAR_EN]}
                        + {3'b000, lc[`FUC_LC_TWO_STOP]};
                end
            end else if (tick) begin
                tx_tick_cnt <= tx_tick_cnt + 4'h1;
                if (tx_tick_cnt == 4'hf) begin
                    tx_frame <= {1'b1, tx_frame[11:1]};
                    tx_bit <= tx_bit + 4'h1;
                    if (tx_bit + 4'h1 == tx_len)
                        tx_busy_shift <= 1'b0;
                end
            end
        end
    end

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            serial_out_o <= 1'b1;
        else
            serial_out_o <= lc[`FUC_LC_BREAK] ? 1'b0
                : (tx_busy_shift ? tx_frame[0] : 1'b1);
    end

    wire busy = !txf_empty || tx_busy_shift;

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    reg pin_s1;
    reg pin_s2;
    // Pin passes two flops before any logic looks at it
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= serial_in_i;
            pin_s2 <= pin_s1;
        end
    end

    wire rx_line = control[`FUC_CT_LOOPBACK] ? serial_out_o : pin_s2;

    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_BITS = 2'd2;
    reg [1:0] rx_state;
    reg [3:0] rx_tick_cnt;
    reg [3:0] rx_bit;
    reg [8:0] rx_shift;
    reg rx_overrun;
    reg [9:0] rto_ticks;
    reg rto_hit;
    reg rx_prev; // Line one clock ago; resets high so reset gives no false edge
    wire [3:0] rx_last = nbits + {3'b000, lc[`FUC_LC_PAR_EN]};

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state <= RX_IDLE;
            rx_tick_cnt <= 4'h0;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            rx_push <= 1'b0;
            rx_word <= 12'h000;
            rx_overrun <= 1'b0;
            rx_prev <= 1'b1;
        end else begin
            rx_push <= 1'b0;
            rx_prev <= rx_line;
            if (wr_ecr)
                rx_overrun <= 1'b0;
            case (rx_state)
                RX_IDLE: begin
                    // A line left low after a bad stop bit must rise before a new start
                    if (rx_en && rx_prev && !rx_line) begin
                        rx_state <= RX_START;
                        rx_tick_cnt <= 4'h0;
                    end
                end
                RX_START: if (tick) begin
                    rx_tick_cnt <= rx_tick_cnt + 4'h1;
                    if (rx_tick_cnt == 4'h7) begin
                        rx_tick_cnt <= 4'h0;
                        rx_bit <= 4'h0;
                        rx_shift <= 9'h000;
                        rx_state <= rx_line ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: if (tick) begin
                    rx_tick_cnt <= rx_tick_cnt + 4'h1;
                    if (rx_tick_cnt == 4'hf) begin
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit < rx_last) begin
                            rx_shift[rx_bit] <= rx_line;
                        end else begin
                            rx_state <= RX_IDLE;
                            rx_push <= 1'b1;
                            // Overrun flag rides with the next pushed word
                            rx_word[11] <= rx_overrun || (rxf_full && !rd_data_now);
                            rx_word[10] <= (rx_shift[7:0] & ~(8'hff << nbits)) == 8'h00
                                && !rx_line && (!lc[`FUC_LC_PAR_EN] || !rx_shift[nbits]);
                            rx_word[9] <= lc[`FUC_LC_PAR_EN]
                                && rx_shift[nbits] != par_bit(rx_shift[7:0], nbits, lc);
                            rx_word[8] <= !rx_line;
                            rx_word[7:0] <= rx_shift[7:0] & ~(8'hff << nbits);
                            if (rxf_full && !rd_data_now)
                                rx_overrun <= 1'b1;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rto_ticks <= 10'h000;
            rto_hit <= 1'b0;
        end else begin
            rto_hit <= 1'b0;
            if (rxf_empty || rx_push || rx_state != RX_IDLE)
                rto_ticks <= 10'h000;
            else if (tick && rto_ticks != 10'h3ff)
                rto_ticks <= rto_ticks + 10'h001;
            else if (tick)
                rto_hit <= 1'b0;
            if (tick && rto_ticks == (`FUC_RX_TIMEOUT_BITS * 16 - 1))
                rto_hit <= 1'b1;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    reg [10:0] raw;
    wire [4:0] tx_thr;
    wire [4:0] rx_thr;

    function [4:0] level_of;
        input [2:0] sel;
        begin
            case (sel)
                3'd0: level_of = 5'd2;
                3'd1: level_of = 5'd4;
                3'd2: level_of = 5'd8;
                3'd3: level_of = 5'd12;
                default: level_of = 5'd14;
            endcase
        end
    endfunction
    assign tx_thr = level_of(level_sel[2:0]);
    assign rx_thr = level_of(level_sel[5:3]);

    wire [10:0] events = {
        rx_push && rxf_full, // Word dropped on a full FIFO
        rx_push && rx_word[10],
        rx_push && rx_word[9],
        rx_push && rx_word[8],
        rto_hit,
        deep ? (txf_count <= tx_thr) : txf_empty,
        deep ? (rxf_count >= rx_thr) : !rxf_empty,
        4'h0};

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            raw <= 11'h000;
        else
            raw <= events | (raw & ~(wr_icr ? hwdata_i[10:0] : 11'h000));
    end

    wire [10:0] masked = raw & irq_mask;
    assign irq_o = |masked;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // flags and overrun
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (start && !hwrite_i) begin
            case ({haddr_i[11:2], 2'b00})
                `FUC_DATA_PORT_OFF: hrdata_o <= {20'h00000, rxf_data};
                `FUC_RX_STATUS_OFF: hrdata_o <= {28'h0000000, rx_overrun, 3'b000};
                `FUC_FLAG_OFF: hrdata_o <= {24'h000000, txf_empty, rxf_full,
                    txf_full, rxf_empty, busy, 3'b000};
                `FUC_INT_DIV_OFF: hrdata_o <= {16'h0000, div_int};
                `FUC_FRAC_DIV_OFF: hrdata_o <= {26'h0000000, div_frac};
                `FUC_LINE_CTRL_OFF: hrdata_o <= {24'h000000, line_ctrl};
                `FUC_CONTROL_OFF: hrdata_o <= {22'h000000, control};
                `FUC_LEVEL_SEL_OFF: hrdata_o <= {26'h0000000, level_sel};
                `FUC_IRQ_MASK_OFF: hrdata_o <= {21'h000000, irq_mask};
                `FUC_RAW_IRQ_OFF: hrdata_o <= {21'h000000, raw};
                `FUC_MASKED_IRQ_OFF: hrdata_o <= {21'h000000, masked};
                default: hrdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule // fuc_core

`default_nettype wire

// ==== verif/fuc_core_asserts.sv ====
// Checker on the transceiver's top ports.
// Assumes word bus transfers and an integer divisor of at least one.
`timescale 1ns/10ps
`default_nettype none
module fuc_core_chk (
    input wire logic clock_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic hsel_i, // Select
    input wire logic [11:0] haddr_i, // Address
    input wire logic [1:0] htrans_i, // Type
    input wire logic hwrite_i, // Write
    input wire logic hready_i, // Ready in
    input wire logic [31:0] hrdata_o, // Read data
    input wire logic hreadyout_o, // Ready out
    input wire logic hresp_o, // Response
    input wire logic serial_out_o, // Line out
    input wire logic irq_o // Request
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Read address phase taken at this edge
    wire logic rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    AST_NO_WAIT: assert property (hreadyout_o && !hresp_o)
        else $error("bus stalled or errored");
    AST_IDLE: assert property ($fell(rst_i) |-> serial_out_o && !irq_o)
        else $error("line not idle after reset");
    // A bit is 16 ticks and a tick is at least one clock
    AST_BIT_LEN: assert property ($fell(serial_out_o) |=> !serial_out_o [*8])
        else $error("low bit too short");
    AST_HOLD: assert property (!rd |=> $stable(hrdata_o))
        else $error("read data moved");
    AST_DATA_W: assert property (rd && haddr_i == 12'h000 |=> hrdata_o[31:12] == 20'h0)
        else $error("data read too wide");
    AST_FLAGS: assert property (rd && haddr_i == 12'h018 |=>
        !(hrdata_o[7] && hrdata_o[5]) && !(hrdata_o[4] && hrdata_o[6]))
        else $error("empty and full together");
    AST_BUSY: assert property (rd && haddr_i == 12'h018 |=> hrdata_o[3] || hrdata_o[7])
        else $error("idle with data queued");
    AST_IRQ: assert property (rd && haddr_i == 12'h040 |=> $past(irq_o) == (hrdata_o[10:0] != 11'h0))
        else $error("request differs from masked status");
endmodule // fuc_core_chk
bind fuc_core fuc_core_chk u_chk (.clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .serial_out_o, .irq_o);
`default_nettype wire

// ==== verif/fuc_remote.sv ====
// Remote serial device: sends frames and captures 8N1 characters.
// Assumes the bit time in clocks matches the programmed divisor.
`timescale 1ns/10ps
`default_nettype none
module fuc_remote #(parameter int BIT_CLKS = 40) (
    input wire logic clock_i, // System clock
    input wire logic line_i, // From transmit pin
    output logic line_o // To receive pin, idle high
);
    logic [7:0] got;
    logic [7:0] got_q[$];
    initial line_o = 1'b1;
    // Sample mid-bit so fractional tick jitter does not matter
    initial begin
        forever begin
            @(negedge line_i);
            repeat (BIT_CLKS / 2) @(posedge clock_i);
            repeat (8) begin
                repeat (BIT_CLKS) @(posedge clock_i);
                got = {line_i, got[7:1]};
            end
            got_q.push_back(got);
        end
    end
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (BIT_CLKS) @(posedge clock_i);
        end
        line_o <= 1'b1;
    endtask
    // Short low glitch on an idle line
    task automatic pulse(input int n);
        line_o <= 1'b0;
        repeat (n) @(posedge clock_i);
        line_o <= 1'b1;
    endtask
endmodule // fuc_remote
`default_nettype wire

// ==== verif/tb.sv ====
// Bench: bus tasks and scenarios for the serial transceiver.
// Assumes the remote model on the pins and a 40-clock bit.
`timescale 1ns/10ps
`default_nettype none
`include "fuc_consts.vh"
module tb;
    localparam int BITC = 40; // Divisor 2.5 times 16
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hrdy;
    logic sin;
    logic sout;
    logic irq;
    logic [31:0] rv;
    int mismatches = 0;
    int cmp_count = 0;
    initial forever #5 clock_i = ~clock_i;
    fuc_core u_dut (.clock_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .serial_in_i(sin),
        .serial_out_o(sout), .irq_o(irq));
    fuc_remote #(.BIT_CLKS(BITC)) u_rem (.clock_i, .line_i(sout), .line_o(sin));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Next edge with ready high; a stuck bus ends the run
    task automatic edge_ready();
        int k;
        k = 0;
        @(posedge clock_i);
        while (hrdy !== 1'b1) begin
            if (++k > 50) begin
                chk(32'h0, 32'h1);
                complete_run();
            end
            @(posedge clock_i);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        edge_ready();
        rv = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    // Poll the flag register until bit b clears
    task automatic poll(input int b);
        int k;
        k = 0;
        do begin
            bus(1'b0, `FUC_FLAG_OFF, 32'h0);
            if (++k > 500) begin
                chk(32'h0, 32'h1);
                complete_run();
            end
        end while (rv[b]);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rdc(`FUC_CONTROL_OFF, 32'h300);
        rdc(`FUC_LEVEL_SEL_OFF, 32'h12);
        rdc(`FUC_FLAG_OFF, 32'h90);
        rdc(12'h100, 32'h0);
        $display("reset test done");
        // Program while disabled, then enable
        wr(`FUC_INT_DIV_OFF, 32'h2);
        wr(`FUC_FRAC_DIV_OFF, 32'h20);
        wr(`FUC_LINE_CTRL_OFF, 32'h70);
        wr(`FUC_CONTROL_OFF, 32'h301);
        wr(`FUC_DATA_PORT_OFF, 32'ha5);
        wr(`FUC_DATA_PORT_OFF, 32'h3c);
        bus(1'b0, `FUC_FLAG_OFF, 32'h0);
        chk(rv & 32'h8, 32'h8);
        poll(3);
        chk(rv, 32'h90);
        chk({24'h0, u_rem.got_q[0]}, 32'ha5);
        chk({24'h0, u_rem.got_q[1]}, 32'h3c);
        $display("transmit test done");
        u_rem.send(8'hc3, 1'b0);
        poll(4);
        rdc(`FUC_DATA_PORT_OFF, 32'h1c3);
        wr(`FUC_IRQ_MASK_OFF, 32'h80);
        rdc(`FUC_MASKED_IRQ_OFF, 32'h80);
        chk({31'h0, irq}, 32'h1);
        wr(`FUC_IRQ_CLEAR_OFF, 32'h80);
        bus(1'b0, `FUC_RAW_IRQ_OFF, 32'h0);
        chk(rv & 32'h80, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Glitch of about three ticks, then a whole character time
        u_rem.pulse(8);
        repeat (10 * BITC) @(posedge clock_i);
        rdc(`FUC_FLAG_OFF, 32'h90);
        // A lone character left unread raises the timeout
        u_rem.send(8'h81, 1'b1);
        repeat (1400) @(posedge clock_i);
        bus(1'b0, `FUC_RAW_IRQ_OFF, 32'h0);
        chk(rv & 32'h40, 32'h40);
        rdc(`FUC_DATA_PORT_OFF, 32'h81);
        $display("receive test done");
        // Loopback over every length with parity and stop variants
        for (int i = 0; i < 4; i++) begin
            wr(`FUC_CONTROL_OFF, 32'h380);
            wr(`FUC_LINE_CTRL_OFF, {24'h0, i == 3, i[1:0], 1'b1, i[0], i[1], 2'b10});
            wr(`FUC_CONTROL_OFF, 32'h381);
            wr(`FUC_DATA_PORT_OFF, 32'h5a);
            poll(4);
            rdc(`FUC_DATA_PORT_OFF, 32'h5a & ~(32'hffffffff << (5 + i)));
        end
        $display("loopback test done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
